// >>> verilog/rtcpa_pkg.sv
/*
  Constants, register map and carrier types of the real-time clock block.
  Assumes a 40 MHz system clock and a single AHB-Lite master.
*/
`default_nettype none
package rtcpa_pkg;

  localparam int          CLK_HZ           = 40_000_000;
  localparam int          DETECT_TIME_US   = 1000;
  localparam int          DETECT_CYCLES    = (CLK_HZ / 1_000_000) * DETECT_TIME_US;
  localparam logic [7:0]  LP_MIN_EDGES     = 8'h04;
  localparam logic [5:0]  PRE64_LAST       = 6'h3F;

  localparam logic [7:0]  OFS_CONTROL      = 8'h00;
  localparam logic [7:0]  OFS_STATUS       = 8'h04;
  localparam logic [7:0]  OFS_TICK_RELOAD  = 8'h08;
  localparam logic [7:0]  OFS_DIVIDER      = 8'h0C;
  localparam logic [7:0]  OFS_TIME         = 8'h10;
  localparam logic [7:0]  OFS_ALARM        = 8'h14;
  localparam logic [7:0]  OFS_NTICK_RELOAD = 8'h18;

  localparam int          CTL_RUN          = 0;
  localparam int          CTL_OSC_OFF      = 1;
  localparam int          CTL_TICK_IE      = 2;
  localparam int          CTL_ALARM_IE     = 3;
  localparam int          CTL_NTICK_IE     = 4;
  localparam int          CTL_KEEP_PD      = 5;
  localparam int          CTL_WIDTH        = 6;

  localparam int          FLG_TICK         = 0;
  localparam int          FLG_ALARM        = 1;
  localparam int          FLG_NTICK        = 2;
  localparam int          STS_LP_SEL       = 3;
  localparam int          STS_DETECT_DONE  = 4;

  localparam logic [5:0]  CONTROL_RESET    = 6'h00;
  localparam logic [19:0] TICK_RELOAD_RESET = 20'h00000;
  localparam logic [15:0] NTICK_RELOAD_RESET = 16'h0000;
  localparam logic [31:0] ALARM_RESET      = 32'hFFFFFFFF;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
    logic [31:0] hwdata;
  } rtcpa_ahb_req_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } rtcpa_ahb_rsp_t;

  typedef struct packed {
    logic tick;
    logic alarm;
    logic ntick;
  } rtcpa_irq_t;

endpackage : rtcpa_pkg
`default_nettype wire

// >>> verilog/rtcpa_in_sync.sv
/*
  Pin input synchroniser: three flip-flops per bit, a level change is taken once
  the second and third stages agree, and a one-cycle pulse marks each rise.
  Assumes asynchronous inputs and the block's synchronous active-low reset.
*/
`default_nettype none
module rtcpa_in_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             i_clk,
  input  wire logic             i_reset_n,
  input  wire logic [WIDTH-1:0] i_pin,
  output logic      [WIDTH-1:0] o_level,
  output logic      [WIDTH-1:0] o_rise
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] level;
    logic [WIDTH-1:0] rise;
  } rtcpa_sync_state_t;

  rtcpa_sync_state_t s_q;
  rtcpa_sync_state_t s_d;

  always_comb begin
    s_d    = s_q;
    s_d.s1 = i_pin;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    for (int b = 0; b < WIDTH; b++) begin
      s_d.level[b] = (s_q.s2[b] == s_q.s3[b]) ? s_q.s3[b] : s_q.level[b];
      s_d.rise[b]  = s_d.level[b] & ~s_q.level[b];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_level = s_q.level;
  assign o_rise  = s_q.rise;

endmodule : rtcpa_in_sync
`default_nettype wire

// >>> verilog/rtcpa_core.sv
/*
  Real-time clock: oscillator detection, divide-by-64 stage, 20-bit reloadable
  divider, 32-bit time counter with alarm, n-tick counter, interrupt flags,
  oscillator control for power down and an AHB-Lite register slave.
  Assumes oscillator pins are far slower than the 40 MHz system clock, the
  chip power-down state and wake configuration arrive as plain inputs, and
  routing of the requests to the external interrupt unit happens outside.
*/
// Implementation choices: the placing of the registers and the AHB-Lite slave port.
`default_nettype none

module rtcpa_core #(
  parameter int DETECT_CYCLES = rtcpa_pkg::DETECT_CYCLES,
  parameter int DIV_WIDTH     = 20,
  parameter int NTICK_WIDTH   = 16
) (
  input  wire logic                     i_clk,
  input  wire logic                     i_reset_n,
  input  wire rtcpa_pkg::rtcpa_ahb_req_t i_ahb,
  output rtcpa_pkg::rtcpa_ahb_rsp_t     o_ahb,
  input  wire logic                     i_main_oscillator_input,
  input  wire logic                     i_low_power_oscillator_input,
  input  wire logic                     i_powerdown,
  input  wire logic                     i_powerdown_wake_config,
  output rtcpa_pkg::rtcpa_irq_t         o_irq,
  output logic                          o_wake,
  output logic                          o_main_osc_enable,
  output logic                          o_lp_osc_enable
);
  import rtcpa_pkg::*;

  typedef enum logic {
    ST_DETECT,
    ST_RUN
  } rtcpa_phase_t;

  typedef struct packed {
    rtcpa_phase_t            phase;
    logic [31:0]             det_cnt;
    logic [7:0]              lp_edges;
    logic                    lp_sel;
    logic [5:0]              pre;
    logic [DIV_WIDTH-1:0]    div;
    logic [DIV_WIDTH-1:0]    tick_period_reload;
    logic [31:0]             time_cnt;
    logic [31:0]             alarm;
    logic                    match;
    logic [NTICK_WIDTH-1:0]  ntick_reload;
    logic [NTICK_WIDTH-1:0]  ntick_cnt;
    logic [CTL_WIDTH-1:0]    clock_block_control;
    logic [2:0]              flags;
    logic                    wr_pend;
    logic [7:0]              wr_addr;
    logic [31:0]             rdata;
    rtcpa_irq_t              irq;
    logic                    wake;
    logic                    main_en;
    logic                    lp_en;
  } rtcpa_state_t;

  rtcpa_state_t s_q;
  rtcpa_state_t s_d;

  logic [1:0] pin_rise;

  rtcpa_in_sync #(
    .WIDTH (2)
  ) u_in_sync (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_pin     ({i_low_power_oscillator_input, i_main_oscillator_input}),
    .o_level   (),
    .o_rise    (pin_rise)
  );

  logic        addr_ok;
  logic        wr_now;
  logic [31:0] wdata;
  logic        run;
  logic        osc_off;
  logic        keep_pd;
  logic        osc_rise;
  logic        count_en;
  logic        stage;
  logic        tick;
  logic        alarm_evt;
  logic        ntick_evt;
  logic [2:0]  flag_set;
  logic [2:0]  flag_clr;
  logic [2:0]  flag_en;
  logic        match_now;

  always_comb begin
    s_d       = s_q;
    wdata     = i_ahb.hwdata;
    run       = s_q.clock_block_control[CTL_RUN];
    osc_off   = s_q.clock_block_control[CTL_OSC_OFF];
    keep_pd   = s_q.clock_block_control[CTL_KEEP_PD];
    addr_ok   = i_ahb.hsel & i_ahb.htrans[1] & i_ahb.hready;
    wr_now    = s_q.wr_pend;

    if (s_q.phase == ST_DETECT) begin
      s_d.det_cnt = s_q.det_cnt + 32'h00000001;
      if (pin_rise[1] && s_q.lp_edges != 8'hFF) begin
        s_d.lp_edges = s_q.lp_edges + 8'h01;
      end
      if (s_q.det_cnt >= 32'(DETECT_CYCLES - 1)) begin
        s_d.lp_sel = (s_q.lp_edges >= LP_MIN_EDGES);
        s_d.phase  = ST_RUN;
      end
    end

    osc_rise = (s_q.phase == ST_RUN) & (s_q.lp_sel ? pin_rise[1] : pin_rise[0]);

    count_en = run & (~i_powerdown | (s_q.lp_sel ? keep_pd : ~osc_off));

    stage = count_en & osc_rise & (s_q.pre == PRE64_LAST);
    if (count_en && osc_rise) begin
      s_d.pre = s_q.pre + 6'h01;
    end

    tick = stage & (s_q.div == '0);
    if (tick) begin
      s_d.div = s_q.tick_period_reload;
    end else if (stage) begin
      s_d.div = s_q.div - DIV_WIDTH'(1);
    end

    if (tick) begin
      s_d.time_cnt = s_q.time_cnt + 32'h00000001;
    end

    match_now = (s_q.time_cnt == s_q.alarm);
    s_d.match = match_now;
    alarm_evt = match_now & ~s_q.match;

    ntick_evt = tick & (s_q.ntick_cnt == '0);
    if (tick) begin
      s_d.ntick_cnt = ntick_evt ? s_q.ntick_reload : s_q.ntick_cnt - NTICK_WIDTH'(1);
    end

    flag_set             = '0;
    flag_set[FLG_TICK]   = tick;
    flag_set[FLG_ALARM]  = alarm_evt;
    flag_set[FLG_NTICK]  = ntick_evt;
    flag_clr             = '0;

    if (wr_now) begin
      unique case (s_q.wr_addr)
        OFS_CONTROL: begin
          s_d.clock_block_control = wdata[CTL_WIDTH-1:0];
        end
        OFS_STATUS: begin
          flag_clr = wdata[2:0];
        end
        OFS_TICK_RELOAD: begin
          s_d.tick_period_reload = wdata[DIV_WIDTH-1:0];
        end
        OFS_TIME: begin
          s_d.time_cnt = wdata;
        end
        OFS_ALARM: begin
          s_d.alarm = wdata;
        end
        OFS_NTICK_RELOAD: begin
          s_d.ntick_reload = wdata[NTICK_WIDTH-1:0];
          s_d.ntick_cnt    = wdata[NTICK_WIDTH-1:0];
        end
        default: begin
        end
      endcase
    end

    s_d.flags = flag_set | (s_q.flags & ~flag_clr);

    flag_en             = '0;
    flag_en[FLG_TICK]   = s_q.clock_block_control[CTL_TICK_IE];
    flag_en[FLG_ALARM]  = s_q.clock_block_control[CTL_ALARM_IE];
    flag_en[FLG_NTICK]  = s_q.clock_block_control[CTL_NTICK_IE];
    s_d.irq.tick  = s_d.flags[FLG_TICK] & flag_en[FLG_TICK];
    s_d.irq.alarm = s_d.flags[FLG_ALARM] & flag_en[FLG_ALARM];
    s_d.irq.ntick = s_d.flags[FLG_NTICK] & flag_en[FLG_NTICK];

    s_d.wake = i_powerdown & i_powerdown_wake_config &
               (s_d.irq.tick | s_d.irq.alarm | s_d.irq.ntick);

    s_d.main_en = ~(i_powerdown & (s_q.lp_sel | ~run | osc_off));
    s_d.lp_en   = ~(i_powerdown & (~run | osc_off));

    s_d.wr_pend = addr_ok & i_ahb.hwrite & (i_ahb.haddr[31:8] == 24'h000000);
    s_d.wr_addr = i_ahb.haddr[7:0];
    if (addr_ok && !i_ahb.hwrite) begin
      s_d.rdata = '0;
      if (i_ahb.haddr[31:8] == 24'h000000) begin
        unique case (i_ahb.haddr[7:0])
          OFS_CONTROL: begin
            s_d.rdata[CTL_WIDTH-1:0] = s_q.clock_block_control;
          end
          OFS_STATUS: begin
            s_d.rdata[2:0]             = s_q.flags;
            s_d.rdata[STS_LP_SEL]      = s_q.lp_sel;
            s_d.rdata[STS_DETECT_DONE] = (s_q.phase == ST_RUN);
          end
          OFS_TICK_RELOAD: begin
            s_d.rdata[DIV_WIDTH-1:0] = s_q.tick_period_reload;
          end
          OFS_DIVIDER: begin
            s_d.rdata[DIV_WIDTH+5:0] = {s_q.div, s_q.pre};
          end
          OFS_TIME: begin
            s_d.rdata = s_q.time_cnt;
          end
          OFS_ALARM: begin
            s_d.rdata = s_q.alarm;
          end
          OFS_NTICK_RELOAD: begin
            s_d.rdata[NTICK_WIDTH-1:0] = s_q.ntick_reload;
          end
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      s_q                     <= '0;
      s_q.phase               <= ST_DETECT;
      s_q.tick_period_reload  <= TICK_RELOAD_RESET[DIV_WIDTH-1:0];
      s_q.div                 <= TICK_RELOAD_RESET[DIV_WIDTH-1:0];
      s_q.alarm               <= ALARM_RESET;
      s_q.ntick_reload        <= NTICK_RELOAD_RESET[NTICK_WIDTH-1:0];
      s_q.ntick_cnt           <= NTICK_RELOAD_RESET[NTICK_WIDTH-1:0];
      s_q.clock_block_control <= CONTROL_RESET;
      s_q.main_en             <= 1'b1;
      s_q.lp_en               <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_irq             = s_q.irq;
  assign o_wake            = s_q.wake;
  assign o_main_osc_enable = s_q.main_en;
  assign o_lp_osc_enable   = s_q.lp_en;

  assign o_ahb.hrdata    = s_q.rdata;
  assign o_ahb.hreadyout = 1'b1;
  assign o_ahb.hresp     = 1'b0;

endmodule : rtcpa_core
`default_nettype wire

// >>> verilog/rtcpa_unused.sv
/*
  Holds no logic; the block lives in the core and synchroniser files.
  Assumes nothing of its surroundings.
*/

// >>> sim/rtcpa_asserts.sv
/*
  Concurrent checks on the real-time clock ports.
  Assumes a bind onto rtcpa_core; it sees only that module's ports.
*/
`default_nettype none
module rtcpa_chk
  import rtcpa_pkg::*;
(
  input wire logic           i_clk,
  input wire logic           i_reset_n,
  input wire rtcpa_ahb_req_t i_ahb,
  input wire rtcpa_ahb_rsp_t o_ahb,
  input wire logic           i_powerdown,
  input wire logic           i_powerdown_wake_config,
  input wire rtcpa_irq_t     o_irq,
  input wire logic           o_wake,
  input wire logic           o_main_osc_enable,
  input wire logic           o_lp_osc_enable
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  logic take;
  logic take_rd;
  logic take_wr;
  assign take    = i_ahb.hsel && i_ahb.htrans[1] && i_ahb.hready;
  assign take_rd = take && !i_ahb.hwrite;
  assign take_wr = take && i_ahb.hwrite;

  ready_okay_a: assert property (o_ahb.hreadyout && !o_ahb.hresp)
    else $error("bus answer not zero-wait OKAY");
  unmapped_zero_a: assert property (
    take_rd && (i_ahb.haddr[31:8] != 24'h000000) |=> o_ahb.hrdata == 32'h00000000)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property ($changed(o_ahb.hrdata) |-> $past(take_rd))
    else $error("read data changed without a read");
  osc_run_a: assert property (!i_powerdown |=> o_main_osc_enable && o_lp_osc_enable)
    else $error("oscillator stopped outside power down");
  lp_off_a: assert property (!o_lp_osc_enable |-> !o_main_osc_enable)
    else $error("main oscillator runs with low-power one off");
  off_needs_pd_a: assert property (!o_main_osc_enable |-> $past(i_powerdown))
    else $error("main oscillator off without power down");
  wake_eq_a: assert property (
    o_wake == ($past(i_powerdown && i_powerdown_wake_config) && (o_irq != 3'h0)))
    else $error("wake output wrong");
  irq_clear_a: assert property (
    $fell(o_irq.tick) |-> $past(take_wr, 2) || $past(take_wr, 3))
    else $error("tick request dropped without a write");
  tick_c: cover property ($rose(o_irq.tick));
  alarm_c: cover property ($rose(o_irq.alarm));
  wake_c: cover property ($rose(o_wake));
endmodule : rtcpa_chk
`default_nettype wire

// >>> sim/tb.sv
/*
  Self-checking bench for the real-time clock, driven over AHB-Lite.
  Assumes rtcpa_core with a short detection window and a 10-cycle (4 MHz) low-power pin.
*/
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rtcpa_pkg::*;
  logic           i_clk, i_reset_n, mosc, lpin, pd, wcfg, wake, men, len;
  rtcpa_ahb_req_t req, bus;
  rtcpa_ahb_rsp_t rsp;
  rtcpa_irq_t     irq;
  logic [31:0]    rdv;
  int             n_fail, checks_done, cyc, t0;

  always #12.5 i_clk = ~i_clk;
  always_comb begin
    bus = req;
    bus.hready = rsp.hreadyout;
  end
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    lpin <= (cyc % 10) < 5;
    mosc <= cyc[1];
    if (cyc == 20000) begin
      n_fail++;
      wrap_up();
    end
  end

  rtcpa_core #(.DETECT_CYCLES(200)) uut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_ahb(bus),
    .o_ahb(rsp), .i_main_oscillator_input(mosc), .i_low_power_oscillator_input(lpin),
    .i_powerdown(pd), .i_powerdown_wake_config(wcfg), .o_irq(irq), .o_wake(wake),
    .o_main_osc_enable(men), .o_lp_osc_enable(len));

  task automatic wrap_up();
    $display("Checks done %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge i_clk);
    req <= '{1'b1, a, 2'h2, wr, 3'h2, 1'b1, req.hwdata};
    do @(posedge i_clk); while (rsp.hreadyout !== 1'b1);
    req.htrans <= 2'h0;
    req.hwdata <= wd;
    do @(posedge i_clk); while (rsp.hreadyout !== 1'b1);
    rdv = rsp.hrdata;
  endtask : xfer
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h00000000);
    chk(rdv, exp);
  endtask : rd
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic wt();
    do @(negedge i_clk); while (irq.tick !== 1'b1);
  endtask : wt

  initial begin
    {i_clk, i_reset_n, mosc, lpin, pd, wcfg} = 6'h00;
    req = '0;
    {n_fail, checks_done, cyc} = 0;
    repeat (20) @(posedge i_clk);
    i_reset_n <= 1'b1;
    rd(32'(OFS_CONTROL), 32'h00000000);
    rd(32'(OFS_ALARM), 32'hFFFFFFFF);
    rd(32'h00000100, 32'h00000000);
    wr(32'h00000100, 32'h0000003F);
    rd(32'(OFS_CONTROL), 32'h00000000);
    repeat (250) @(posedge i_clk);
    rd(32'(OFS_STATUS), 32'h00000018);
    wr(32'(OFS_TICK_RELOAD), 32'h00000001);
    wr(32'(OFS_TIME), 32'hFFFFFFFF);
    wr(32'(OFS_ALARM), 32'h00000000);
    wr(32'(OFS_CONTROL), 32'h0000000D);
    wt();
    t0 = cyc;
    repeat (3) @(negedge i_clk);
    chk(32'(irq), 32'h00000006);
    rd(32'(OFS_STATUS), 32'h0000001F);
    rd(32'(OFS_TIME), 32'h00000000);
    wr(32'(OFS_STATUS), 32'h00000007);
    repeat (3) @(negedge i_clk);
    chk(32'(irq), 32'h00000000);
    wt();
    chk(32'(cyc - t0), 32'h00000500);
    rd(32'(OFS_TIME), 32'h00000001);
    wr(32'(OFS_STATUS), 32'h00000007);
    @(posedge i_clk);
    pd <= 1'b1;
    repeat (3) @(negedge i_clk);
    chk({30'h0, men, len}, 32'h00000001);
    repeat (1500) @(negedge i_clk);
    rd(32'(OFS_TIME), 32'h00000001);
    wcfg <= 1'b1;
    wr(32'(OFS_CONTROL), 32'h00000025);
    wt();
    chk(32'(wake), 32'h00000001);
    rd(32'(OFS_TIME), 32'h00000002);
    wr(32'(OFS_STATUS), 32'h00000007);
    wr(32'(OFS_CONTROL), 32'h00000003);
    repeat (3) @(negedge i_clk);
    chk({30'h0, men, len}, 32'h00000000);
    rd(32'(OFS_CONTROL), 32'h00000003);
    @(posedge i_clk);
    pd <= 1'b0;
    repeat (3) @(negedge i_clk);
    chk({30'h0, men, len}, 32'h00000003);
    wrap_up();
  end
endmodule : tb

bind rtcpa_core rtcpa_chk u_chk (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_ahb(i_ahb),
  .o_ahb(o_ahb), .i_powerdown(i_powerdown), .i_powerdown_wake_config(i_powerdown_wake_config),
  .o_irq(o_irq), .o_wake(o_wake), .o_main_osc_enable(o_main_osc_enable),
  .o_lp_osc_enable(o_lp_osc_enable));
`default_nettype wire
